/* logic/oscpr_axil.sv */
`timescale 1ns/1ps
`default_nettype none
module oscpr_axil (
	input wire logic clk_i,
	input wire logic rst_ni,
	input wire logic [11:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [11:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	oscpr_reg_if.slave r
);
	logic aw_have_q, w_have_q, ar_have_q; // held requests
	logic [9:0] awidx_q, aridx_q; // held indexes
	logic [7:0] wbyte_q; // held low data byte
	logic wstrb0_q; // held low lane strobe
	logic aw_take, w_take, ar_take, do_wr, do_rd;

	assign aw_take = awvalid_i & awready_o;
	assign w_take = wvalid_i & wready_o;
	assign ar_take = arvalid_i & arready_o;
	// write fires once both halves are held and no answer is pending
	assign do_wr = aw_have_q & w_have_q & ~bvalid_o;
	assign do_rd = ar_have_q & ~rvalid_o;
	assign r.wr = do_wr;
	assign r.rd = do_rd & ~do_wr;
	// reads wait one cycle behind a write so both share one index path
	assign r.idx = do_wr ? awidx_q : aridx_q;
	assign r.wdata = wbyte_q;
	assign r.wstrb0 = wstrb0_q;

	// write channel: address and data taken in either order
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_o <= 1'b0;
			wready_o <= 1'b0;
			awidx_q <= '0;
			wbyte_q <= '0;
			wstrb0_q <= 1'b0;
			bvalid_o <= 1'b0;
			bresp_o <= oscpr_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awidx_q <= awaddr_i[11:2];
			end
			if (w_take) begin
				wbyte_q <= wdata_i[7:0];
				wstrb0_q <= wstrb_i[0];
			end
			aw_have_q <= (aw_have_q | aw_take) & ~do_wr;
			w_have_q <= (w_have_q | w_take) & ~do_wr;
			// ready drops after a take and returns once the answer is gone
			awready_o <= ~(aw_have_q | aw_take) & ~bvalid_o & ~do_wr;
			wready_o <= ~(w_have_q | w_take) & ~bvalid_o & ~do_wr;
			if (do_wr) begin
				bvalid_o <= 1'b1;
				bresp_o <= r.hit ? oscpr_pkg::RESP_OKAY
					: oscpr_pkg::RESP_SLVERR;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// read channel: data registered one cycle after the address is held
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			ar_have_q <= 1'b0;
			arready_o <= 1'b0;
			aridx_q <= '0;
			rvalid_o <= 1'b0;
			rdata_o <= '0;
			rresp_o <= oscpr_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				aridx_q <= araddr_i[11:2];
			end
			ar_have_q <= (ar_have_q | ar_take) & ~r.rd;
			arready_o <= ~(ar_have_q | ar_take) & ~rvalid_o & ~r.rd;
			if (r.rd) begin
				rvalid_o <= 1'b1;
				rdata_o <= {24'h000000, r.rdata};
				rresp_o <= r.hit ? oscpr_pkg::RESP_OKAY
					: oscpr_pkg::RESP_SLVERR;
			end else if (rready_i) begin
				rvalid_o <= 1'b0;
			end
		end
	end
endmodule // oscpr_axil
`default_nettype wire

/* logic/oscpr_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module oscpr_filter #(
	parameter int unsigned QUAL_EDGES = oscpr_pkg::QUAL_EDGES,
	parameter int unsigned LOSS_CYCLES = oscpr_pkg::LOSS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_ni,
	oscpr_filt_if.filt f
);
	localparam int unsigned LW = $clog2(LOSS_CYCLES + 1);
	localparam int unsigned TW = oscpr_pkg::TICK_W;
	if (QUAL_EDGES < 1 || QUAL_EDGES > 15 || LOSS_CYCLES < 4) begin : g_bad
		$error("oscpr_filter: parameter out of range");
	end
	logic cin_q; // previous crystal sample, for edge detection
	logic [TW-1:0] tick_q; // vco cycles since last accepted edge
	logic [3:0] good_q; // accepted edges in a row
	logic [LW-1:0] idle_q; // bus cycles since the last rising crystal edge
	logic loss_q;
	oscpr_pkg::oscpr_fstate_t st_q;
	logic rise, filt_on, acc, miss, gone, in_win, sync_edge;
	logic [TW-1:0] exp_cnt, lo, hi, cnt;

	assign rise = f.crystal_in & ~cin_q;
	assign filt_on = f.ratio != oscpr_pkg::FILT_OFF;
	// one crystal period is twice the half ratio in vco cycles
	assign exp_cnt = {1'b0, f.ratio, 1'b0};
	assign lo = f.wide ? exp_cnt - 7'h01 : exp_cnt;
	assign hi = f.wide ? exp_cnt + 7'h01 : exp_cnt;
	// vco cycles since the last taken edge, this cycle's tick included
	assign cnt = tick_q + {{(TW-1){1'b0}}, f.vco_tick};
	assign in_win = cnt >= lo && cnt <= hi;
	// with no run yet the first edge sets the timing reference and counts as the first good edge
	assign sync_edge = rise && good_q == 4'h0;
	// early edges are noise and get swallowed; only window edges and the sync edge count, or every edge with the filter off
	assign acc = rise & (~filt_on | in_win | sync_edge);
	assign miss = filt_on & (cnt > hi);
	assign gone = f.en & (idle_q == LW'(LOSS_CYCLES - 1));
	assign f.qualified = st_q == oscpr_pkg::OSCPR_F_GOOD;
	assign f.loss = loss_q;

	// edge sampling and vco cycle counting between expected edges
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			cin_q <= 1'b0;
			tick_q <= '0;
		end else begin
			cin_q <= f.crystal_in;
			if (!f.en || acc || miss) begin
				tick_q <= '0;
			end else if (f.vco_tick && tick_q != '1) begin
				tick_q <= tick_q + 7'h01;
			end
		end
	end

	// loss watch: a stopped crystal gives no edges at all
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			idle_q <= '0;
			loss_q <= 1'b0;
		end else begin
			loss_q <= gone;
			if (!f.en || rise || gone) begin
				idle_q <= '0;
			end else begin
				idle_q <= idle_q + LW'(1);
			end
		end
	end

	// qualification: a run of accepted edges, broken by a miss or loss
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			st_q <= oscpr_pkg::OSCPR_F_OFF;
			good_q <= '0;
		end else begin
			unique case (st_q)
				oscpr_pkg::OSCPR_F_OFF: begin
					good_q <= '0;
					if (f.en) begin
						st_q <= oscpr_pkg::OSCPR_F_HUNT;
					end
				end
				oscpr_pkg::OSCPR_F_HUNT, oscpr_pkg::OSCPR_F_GOOD: begin
					if (!f.en) begin
						st_q <= oscpr_pkg::OSCPR_F_OFF;
					end else if (f.clr || miss || gone) begin
						st_q <= oscpr_pkg::OSCPR_F_HUNT;
						good_q <= '0;
					end else if (acc && good_q == 4'(QUAL_EDGES - 1)) begin
						st_q <= oscpr_pkg::OSCPR_F_GOOD;
						good_q <= 4'(QUAL_EDGES);
					end else if (acc && st_q == oscpr_pkg::OSCPR_F_HUNT) begin
						good_q <= good_q + 4'h1;
					end
				end
				default: st_q <= oscpr_pkg::OSCPR_F_OFF;
			endcase
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_ni);
	a_narrow_edge: assert property (
		acc && filt_on && !f.wide && !sync_edge |-> cnt == exp_cnt)
		else $error("narrow filter took an edge off the single slot");
	a_wide_edge: assert property (
		acc && filt_on && f.wide && !sync_edge |-> cnt + 7'h01 >= exp_cnt
			&& cnt <= exp_cnt + 7'h01)
		else $error("wide filter took an edge outside three slots");
endmodule // oscpr_filter
`default_nettype wire

/* logic/oscpr_ifs.sv */
`timescale 1ns/1ps
`default_nettype none
// register requests from the bus slave to the register file
interface oscpr_reg_if;
	logic wr; // one-cycle write strobe
	logic rd; // one-cycle read strobe
	logic [9:0] idx; // register index
	logic [7:0] wdata; // low byte of write data
	logic wstrb0; // low byte lane enabled
	logic [7:0] rdata; // read value, valid with rd
	logic hit; // index is mapped
	modport slave (output wr, rd, idx, wdata, wstrb0, input rdata, hit);
	modport regs (input wr, rd, idx, wdata, wstrb0, output rdata, hit);
endinterface
// control and result of the adaptive oscillator filter
interface oscpr_filt_if;
	logic en; // oscillator running
	logic wide; // wide acceptance window
	logic [4:0] ratio; // half the vco to crystal ratio, zero = off
	logic clr; // drop qualification
	logic vco_tick; // one pulse per vco cycle
	logic crystal_in; // sampled crystal input pin
	logic qualified; // oscillation judged stable
	logic loss; // one-cycle pulse when oscillation stopped
	modport ctrl (output en, wide, ratio, clr, vco_tick, crystal_in,
		input qualified, loss);
	modport filt (input en, wide, ratio, clr, vco_tick, crystal_in,
		output qualified, loss);
endinterface
`default_nettype wire

/* logic/oscpr_pkg.sv */
`default_nettype none
package oscpr_pkg;
	// register indexes; byte address is four times the index
	localparam int unsigned IDX_W = 10;
	localparam logic [9:0] OSC_CFG_IDX = 10'h2fa;
	localparam logic [9:0] WPROTECT_IDX = 10'h2fb;
	localparam logic [9:0] STATUS_IDX = 10'h300;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h301;
	localparam logic [9:0] IRQ_MASK_IDX = 10'h302;
	// oscillator_config fields
	localparam int unsigned OSC_EN_BIT = 7;
	localparam int unsigned WIDE_BW_BIT = 6;
	localparam int unsigned PINS_BIT = 5;
	localparam int unsigned FILT_W = 5;
	localparam logic [4:0] FILT_OFF = 5'h00;
	localparam logic [7:0] OSC_CFG_RST = 8'h00;
	// clock_write_protect: key that unlocks, reset state of the lock
	localparam logic [7:0] UNLOCK_KEY = 8'h26;
	localparam logic WLOCK_RST = 1'b0;
	// status bits and interrupt event bits
	localparam int unsigned ST_QUAL_BIT = 0;
	localparam int unsigned ST_WLOCK_BIT = 1;
	localparam int unsigned EV_W = 3;
	localparam int unsigned EV_QUAL = 0;
	localparam int unsigned EV_LOSS = 1;
	localparam int unsigned EV_BLOCKED = 2;
	// filter timing: good edges to qualify, bus cycles without edge = loss
	localparam int unsigned QUAL_EDGES = 4;
	localparam int unsigned LOSS_CYCLES = 256;
	localparam int unsigned TICK_W = 7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// filter qualification states
	typedef enum logic [1:0] {OSCPR_F_OFF, OSCPR_F_HUNT, OSCPR_F_GOOD}
		oscpr_fstate_t;
endpackage
`default_nettype wire

/* logic/oscpr_top.sv */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module oscpr_top #(
	parameter int unsigned QUAL_EDGES = oscpr_pkg::QUAL_EDGES,
	parameter int unsigned LOSS_CYCLES = oscpr_pkg::LOSS_CYCLES
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [11:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [11:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic PLL_SELECT_I,
	input wire logic VCO_TICK_I,
	input wire logic CRYSTAL_IN_I,
	input wire logic ALT_OUT_I,
	input wire logic ALT_OE_N_I,
	output logic CRYSTAL_OUT_O,
	output logic CRYSTAL_OUT_OE_N_O,
	output logic ALT_IN_O,
	output logic OSC_ENABLE_O,
	output logic CLK_MON_EN_O,
	output logic REF_FROM_CRYSTAL_O,
	output logic PINS_RESERVED_O,
	output logic OSC_QUALIFIED_O,
	output logic MON_RESET_O,
	output logic PLL_LOCK_CLR_O,
	output logic CFG_WRITE_OK_O,
	output logic IRQ_O
);
	localparam int unsigned EW = oscpr_pkg::EV_W;
	oscpr_reg_if rb ();
	oscpr_filt_if fb ();

	logic osc_en_q; // oscillator enable
	logic wide_q; // filter wide band
	logic [4:0] filt_q; // filter half ratio field
	logic pins_q; // crystal pins reserved, sticky until reset
	logic wlock_q; // configuration write lock
	logic qual_q; // registered qualified flag
	logic [EW-1:0] ist_q, ist_d; // interrupt status, write one to clear
	logic [EW-1:0] imask_q; // interrupt mask
	logic [EW-1:0] ev; // events of this cycle
	logic cfg_wr, cfg_eff, lock_wr;

	// true when a write strobe targets the given register on lane 0
	function automatic logic wr_to(input logic [9:0] idx);
		return rb.wr && rb.wstrb0 && rb.idx == idx;
	endfunction

	oscpr_axil u_axil (
		.clk_i(CLK_I),
		.rst_ni(NRST_I),
		.awaddr_i(S_AXI_AWADDR_I),
		.awvalid_i(S_AXI_AWVALID_I),
		.awready_o(S_AXI_AWREADY_O),
		.wdata_i(S_AXI_WDATA_I),
		.wstrb_i(S_AXI_WSTRB_I),
		.wvalid_i(S_AXI_WVALID_I),
		.wready_o(S_AXI_WREADY_O),
		.bresp_o(S_AXI_BRESP_O),
		.bvalid_o(S_AXI_BVALID_O),
		.bready_i(S_AXI_BREADY_I),
		.araddr_i(S_AXI_ARADDR_I),
		.arvalid_i(S_AXI_ARVALID_I),
		.arready_o(S_AXI_ARREADY_O),
		.rdata_o(S_AXI_RDATA_O),
		.rresp_o(S_AXI_RRESP_O),
		.rvalid_o(S_AXI_RVALID_O),
		.rready_i(S_AXI_RREADY_I),
		.r(rb.slave)
	);

	oscpr_filter #(
		.QUAL_EDGES(QUAL_EDGES),
		.LOSS_CYCLES(LOSS_CYCLES)
	) u_filter (
		.clk_i(CLK_I),
		.rst_ni(NRST_I),
		.f(fb.filt)
	);

	// filter is steered straight from the configuration flops
	assign fb.en = osc_en_q;
	assign fb.wide = wide_q;
	assign fb.ratio = filt_q;
	assign fb.clr = cfg_eff;
	assign fb.vco_tick = VCO_TICK_I;
	assign fb.crystal_in = CRYSTAL_IN_I;

	assign cfg_wr = wr_to(oscpr_pkg::OSC_CFG_IDX);
	// a blocked write is dropped and raises the blocked event; the bus still answers okay
	assign cfg_eff = cfg_wr && !wlock_q && PLL_SELECT_I;
	assign lock_wr = wr_to(oscpr_pkg::WPROTECT_IDX);

	// configuration register; reservation bit is not software writable
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			osc_en_q <= oscpr_pkg::OSC_CFG_RST[oscpr_pkg::OSC_EN_BIT];
			wide_q <= oscpr_pkg::OSC_CFG_RST[oscpr_pkg::WIDE_BW_BIT];
			filt_q <= oscpr_pkg::OSC_CFG_RST[oscpr_pkg::FILT_W-1:0];
		end else if (cfg_eff) begin
			osc_en_q <= rb.wdata[oscpr_pkg::OSC_EN_BIT];
			wide_q <= rb.wdata[oscpr_pkg::WIDE_BW_BIT];
			filt_q <= rb.wdata[oscpr_pkg::FILT_W-1:0];
		end
	end

	// pin reservation only ever sets; only reset takes it back
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pins_q <= oscpr_pkg::OSC_CFG_RST[oscpr_pkg::PINS_BIT];
		end else begin
			pins_q <= pins_q | osc_en_q;
		end
	end

	// write lock: the key opens, every other value closes
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			wlock_q <= oscpr_pkg::WLOCK_RST;
		end else if (lock_wr) begin
			wlock_q <= rb.wdata != oscpr_pkg::UNLOCK_KEY;
		end
	end

	// oscillator control and clock routing outputs
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			OSC_ENABLE_O <= 1'b0;
			CLK_MON_EN_O <= 1'b0;
			REF_FROM_CRYSTAL_O <= 1'b0;
			MON_RESET_O <= 1'b0;
			PLL_LOCK_CLR_O <= 1'b0;
			CFG_WRITE_OK_O <= 1'b0;
			qual_q <= 1'b0;
		end else begin
			OSC_ENABLE_O <= osc_en_q;
			CLK_MON_EN_O <= osc_en_q;
			// low means the pll reference is the internal rc clock
			REF_FROM_CRYSTAL_O <= osc_en_q;
			// the monitor only fires while the oscillator is wanted
			MON_RESET_O <= osc_en_q && fb.loss;
			PLL_LOCK_CLR_O <= cfg_eff;
			// other clock registers take writes only while this is high
			CFG_WRITE_OK_O <= ~wlock_q;
			// cleared with the write so a stale pass cannot leak through
			qual_q <= fb.qualified && !cfg_eff;
		end
	end
	assign OSC_QUALIFIED_O = qual_q;

	// crystal pins: oscillator owns both while reserved
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PINS_RESERVED_O <= 1'b0;
			CRYSTAL_OUT_O <= 1'b0;
			CRYSTAL_OUT_OE_N_O <= 1'b1;
			ALT_IN_O <= 1'b0;
		end else begin
			PINS_RESERVED_O <= pins_q;
			if (pins_q) begin
				// inverting amplifier drive; other functions see nothing
				CRYSTAL_OUT_O <= ~CRYSTAL_IN_I;
				CRYSTAL_OUT_OE_N_O <= 1'b0;
				ALT_IN_O <= 1'b0;
			end else begin
				CRYSTAL_OUT_O <= ALT_OUT_I;
				CRYSTAL_OUT_OE_N_O <= ALT_OE_N_I;
				ALT_IN_O <= CRYSTAL_IN_I;
			end
		end
	end

	// interrupt events: qualified rising, oscillation lost, write blocked
	always_comb begin
		ev = '0;
		ev[oscpr_pkg::EV_QUAL] = fb.qualified && !qual_q && !cfg_eff;
		ev[oscpr_pkg::EV_LOSS] = osc_en_q && fb.loss;
		ev[oscpr_pkg::EV_BLOCKED] = cfg_wr && !cfg_eff;
		ist_d = ist_q;
		if (wr_to(oscpr_pkg::IRQ_STAT_IDX)) begin
			ist_d = ist_d & ~rb.wdata[EW-1:0];
		end
		// a new event in the clearing cycle survives the clear
		ist_d = ist_d | ev;
	end

	// interrupt status, mask and the single level output
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ist_q <= '0;
			imask_q <= '0;
			IRQ_O <= 1'b0;
		end else begin
			ist_q <= ist_d;
			if (wr_to(oscpr_pkg::IRQ_MASK_IDX)) begin
				imask_q <= rb.wdata[EW-1:0];
			end
			IRQ_O <= |(ist_q & imask_q);
		end
	end

	// read mux; unmapped indexes answer with an error response
	always_comb begin
		rb.rdata = 8'h00;
		rb.hit = 1'b1;
		unique case (rb.idx)
			oscpr_pkg::OSC_CFG_IDX: begin
				rb.rdata[oscpr_pkg::OSC_EN_BIT] = osc_en_q;
				rb.rdata[oscpr_pkg::WIDE_BW_BIT] = wide_q;
				rb.rdata[oscpr_pkg::PINS_BIT] = pins_q;
				rb.rdata[oscpr_pkg::FILT_W-1:0] = filt_q;
			end
			oscpr_pkg::WPROTECT_IDX: rb.rdata[0] = wlock_q;
			oscpr_pkg::STATUS_IDX: begin
				rb.rdata[oscpr_pkg::ST_QUAL_BIT] = qual_q;
				rb.rdata[oscpr_pkg::ST_WLOCK_BIT] = wlock_q;
			end
			oscpr_pkg::IRQ_STAT_IDX: rb.rdata[EW-1:0] = ist_q;
			oscpr_pkg::IRQ_MASK_IDX: rb.rdata[EW-1:0] = imask_q;
			default: rb.hit = 1'b0;
		endcase
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_key_write;
		lock_wr && rb.wdata == oscpr_pkg::UNLOCK_KEY;
	endsequence
	sequence s_other_write;
		lock_wr && rb.wdata != oscpr_pkg::UNLOCK_KEY;
	endsequence
	a_key_unlocks: assert property (s_key_write |=> !wlock_q)
		else $error("key write did not open the lock");
	a_other_locks: assert property (
		s_other_write |=> wlock_q ##1 !CFG_WRITE_OK_O)
		else $error("non key write did not close the lock");
	a_blocked_write: assert property (
		cfg_wr && (wlock_q || !PLL_SELECT_I) |=> $stable(osc_en_q)
			&& $stable(filt_q) && $stable(wide_q))
		else $error("blocked configuration write changed a field");
	a_write_clears: assert property (
		cfg_eff |=> PLL_LOCK_CLR_O && !OSC_QUALIFIED_O)
		else $error("effective write left lock or qualified flag");
	a_pins_sticky: assert property (pins_q |=> pins_q)
		else $error("pin reservation fell without reset");
	a_pins_follow: assert property (
		osc_en_q |-> ##1 pins_q ##1 PINS_RESERVED_O)
		else $error("enable did not reserve the crystal pins");
	a_pins_owned: assert property (
		pins_q |=> !CRYSTAL_OUT_OE_N_O && !ALT_IN_O)
		else $error("reserved crystal pin handed to another function");
	a_ref_select: assert property (
		!osc_en_q [*2] |-> !REF_FROM_CRYSTAL_O && !OSC_ENABLE_O)
		else $error("reference not from rc clock with oscillator off");
	a_monitor_reset: assert property (
		osc_en_q && fb.loss |=> MON_RESET_O && CLK_MON_EN_O)
		else $error("lost oscillation did not raise monitor reset");
	a_lock_upper: assert property (
		rb.rd && rb.idx == oscpr_pkg::WPROTECT_IDX |-> rb.rdata[7:1] == 7'h00)
		else $error("lock register upper bits not zero");
	// a steady enable must show core, monitor and crystal reference on
	a_osc_on: assert property (
		osc_en_q [*2] |-> OSC_ENABLE_O && CLK_MON_EN_O
			&& REF_FROM_CRYSTAL_O)
		else $error("oscillator enabled but core, monitor or reference off");
	// the flag may only follow what the filter judged one cycle before
	a_qual_follows: assert property (
		OSC_QUALIFIED_O |-> $past(fb.qualified))
		else $error("qualified flag raised without the filter");
endmodule // oscpr_top
`default_nettype wire

/* sim/oscpr_crystal_output_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// crystal on the oscillator pins; a stopped crystal leaves its pin low
module oscpr_crystal_output_pin_model (
	input wire logic clk_i,
	input wire logic run_i, // crystal oscillating
	input wire logic [3:0] period_i, // period in bus cycles
	output logic crystal_o, // crystal input pin level
	output logic vco_tick_o // vco pulse
);
	logic [3:0] ph_q; // phase within one period
	// held at zero while stopped so a restart is clean
	always_ff @(posedge clk_i) begin
		if (!run_i || ph_q >= period_i - 4'h1) begin
			ph_q <= 4'h0;
		end else begin
			ph_q <= ph_q + 4'h1;
		end
	end
	// high for the first half period
	assign crystal_o = run_i && (ph_q < {1'b0, period_i[3:1]});
	// vco is faster than the bus, so a tick lands every bus cycle
	assign vco_tick_o = 1'b1;
endmodule // oscpr_crystal_output_pin_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic psel = 1'b1; // pll selected
	logic run = 1'b0; // crystal stopped
	logic [3:0] per = 4'h4; // crystal period
	logic awrdy, wrdy, bvld, arrdy, rvld, xin, vtick, xout, xoe_n, alt_in;
	logic osc_en, mon_en, ref_x, pins, qual, mon_rst, lock_clr, cfg_ok, irq;
	logic hit;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, v;
	int n_mismatch = 0, total_checks = 0, n_clr = 0;
	oscpr_top #(.LOSS_CYCLES(16)) u_oscpr_top (
		.CLK_I(clk), .NRST_I(nrst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvld), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvld),
		.S_AXI_RREADY_I(rready), .PLL_SELECT_I(psel),
		.VCO_TICK_I(vtick), .CRYSTAL_IN_I(xin), .ALT_OUT_I(1'b0),
		.ALT_OE_N_I(1'b1), .CRYSTAL_OUT_O(xout),
		.CRYSTAL_OUT_OE_N_O(xoe_n), .ALT_IN_O(alt_in),
		.OSC_ENABLE_O(osc_en), .CLK_MON_EN_O(mon_en),
		.REF_FROM_CRYSTAL_O(ref_x), .PINS_RESERVED_O(pins),
		.OSC_QUALIFIED_O(qual), .MON_RESET_O(mon_rst),
		.PLL_LOCK_CLR_O(lock_clr), .CFG_WRITE_OK_O(cfg_ok), .IRQ_O(irq)
	);
	oscpr_crystal_output_pin_model u_oscpr_crystal_output_pin_model (.clk_i(clk), .run_i(run),
		.period_i(per), .crystal_o(xin), .vco_tick_o(vtick));
	always #2.5 clk = ~clk;
	// counts effective config writes; blocked ones must not pulse
	always @(posedge clk) if (lock_clr === 1'b1) n_clr++;
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	// write: both channels offered together, each dropped when taken
	task automatic axw(input logic [9:0] ix, input logic [7:0] d);
		awaddr <= {ix, 2'h0};
		wdata <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bvld);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axr(input logic [9:0] ix);
		araddr <= {ix, 2'h0};
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arrdy) arv <= 1'b0;
		end while (!rvld);
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// bounded wait for the qualified flag to reach a level
	task automatic waitq(input logic e);
		repeat (200) begin
			if (qual === e) break;
			@(posedge clk);
		end
		chkb("qual", e, qual);
	endtask
	task automatic t_reset;
		axr(10'h2fa);
		chk("cfg", 32'h0, v);
		axr(10'h2fb);
		chk("lock", 32'h0, v);
		chkb("ref_x", 1'b0, ref_x);
		chkb("oe_n", 1'b1, xoe_n);
		chkb("xout", 1'b0, xout);
		axw(10'h3ff, 8'h00);
		chk("resp", {30'h0, 2'h2}, {30'h0, rsp});
		axr(10'h3ff);
		chk("rdata", 32'h0, v);
		chk("rresp", {30'h0, 2'h2}, {30'h0, rsp});
		$display("reset done");
	endtask
	task automatic t_protect;
		axw(10'h2fb, 8'hfe);
		axr(10'h2fb);
		chk("lock", 32'h1, v);
		chkb("cfg_ok", 1'b0, cfg_ok);
		axw(10'h2fa, 8'h80);
		chk("resp", 32'h0, {30'h0, rsp});
		axr(10'h2fa);
		chk("cfg", 32'h0, v);
		axr(10'h301);
		chkb("blocked", 1'b1, v[2]);
		axw(10'h2fb, 8'h26);
		axr(10'h2fb);
		chk("lock", 32'h0, v);
		chkb("cfg_ok", 1'b1, cfg_ok);
		psel <= 1'b0;
		axw(10'h2fa, 8'h80);
		axr(10'h2fa);
		chk("cfg", 32'h0, v);
		psel <= 1'b1;
		axw(10'h301, 8'h07);
		$display("protect done");
	endtask
	task automatic t_enable;
		run <= 1'b1;
		axw(10'h302, 8'h01);
		axw(10'h2fa, 8'h82);
		repeat (3) @(posedge clk);
		chkb("osc_en", 1'b1, osc_en);
		chkb("mon_en", 1'b1, mon_en);
		chkb("ref_x", 1'b1, ref_x);
		chkb("oe_n", 1'b0, xoe_n);
		chkb("alt_in", 1'b0, alt_in);
		axr(10'h2fa);
		chk("cfg", 32'ha2, v);
		waitq(1'b1);
		axr(10'h300);
		chkb("st_qual", 1'b1, v[0]);
		chkb("irq", 1'b1, irq);
		$display("enable done");
	endtask
	task automatic t_window;
		per <= 4'h5;
		axw(10'h2fa, 8'h82);
		waitq(1'b0);
		repeat (150) @(posedge clk);
		chkb("qual", 1'b0, qual);
		axw(10'h2fa, 8'h80);
		waitq(1'b1);
		axw(10'h2fa, 8'hc2);
		waitq(1'b0);
		waitq(1'b1);
		$display("window done");
	endtask
	task automatic t_loss;
		axw(10'h302, 8'h00);
		run <= 1'b0;
		hit = 1'b0;
		repeat (60) begin
			@(posedge clk);
			if (mon_rst === 1'b1) hit = 1'b1;
		end
		chkb("mon_rst", 1'b1, hit);
		axr(10'h301);
		chkb("ev_loss", 1'b1, v[1]);
		chkb("irq", 1'b0, irq);
		axw(10'h302, 8'h02);
		repeat (2) @(posedge clk);
		chkb("irq", 1'b1, irq);
		axw(10'h2fa, 8'h00);
		axw(10'h301, 8'h07);
		repeat (2) @(posedge clk);
		chkb("irq", 1'b0, irq);
		axr(10'h2fa);
		chk("cfg", 32'h20, v);
		chkb("ref_x", 1'b0, ref_x);
		chkb("pins", 1'b1, pins);
		chkb("xout", 1'b1, xout);
		chk("clr", 32'h5, n_clr);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		axw(10'h2fa, 8'h20);
		axr(10'h2fa);
		chk("cfg", 32'h0, v);
		chkb("pins", 1'b0, pins);
		$display("loss done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog: the tests need about 400 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset;
		t_protect;
		t_enable;
		t_window;
		t_loss;
		wrap_up;
	end
endmodule // tb
`default_nettype wire
